// File: rtl/dac_playback_volume_path.sv
// Contract
// R1 - upsample by the oversampling ratio, linear phase, 21 sample group delay; code path gives 22 (gain register, 20-stage delay line, interpolator)
// R2 - interpolation images below 7.455 fs attenuated by at least 65 dB
// R3 - host keeps reference rate 39-53 kHz with one shared codec divider
// R4 - third-order multibit delta-sigma modulator converts the interpolated stream
// R5 - six-tap reconstruction FIR runs at 128 times the reference rate
// R6 - per channel gain 0 to -63.5 dB in 0.5 dB steps plus mute
// R7 - master volume sets both channel gains at once
// R8 - applied gain steps one increment per input sample toward target
// R9 - slow bit makes the ramp step once every two samples
// R10 - read-only flag shows ramp finished and applied gain equals target
// R11 - a setting turns gain ramping off entirely
// R12 - host keeps master clock running until power-down flag is set
// R13 - power-down flag only after gain ramp and power-down sequence complete
// R14 - filter toggle: ramp to mute, change filtering, ramp back up
// R15 - at power-up gain starts muted and ramps up to target
// R16 - at power-down ramp to mute first, then power down circuitry
// R17 - register 109 bits 7-6 select bias current, lowest is reset default
// R18 - a field selects one of four output common-mode levels
// R19 - whole dac and each channel analog section powered independently
// R20 - gain code counts 0.5 dB steps, zero is 0 dB, saturates -63.5 dB
// R21 - ramp off: new target applies next sample, done flag immediate
`timescale 1ns/100ps
module dac_playback_volume_path
    import dac_playback_pkg::*;
#(
    parameter int REFERENCE_SAMPLE_RATE_HZ = REFERENCE_SAMPLE_RATE_DEFAULT_HZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample stream from the serial audio port
    input wire logic sample_valid,
    input wire logic signed [15:0] sample_left,
    input wire logic signed [15:0] sample_right,
    // control settings
    input wire logic [2:0] codec_rate_divider,
    input wire logic dac_power_en,
    input wire logic [1:0] chan_power_en,
    input wire logic [6:0] vol_left,
    input wire logic [6:0] vol_right,
    input wire logic mute_left,
    input wire logic mute_right,
    input wire logic master_vol_sel,
    input wire logic [6:0] master_vol,
    input wire logic ramp_slow,
    input wire logic ramp_off,
    input wire logic deemph_en,
    input wire logic effects_en,
    input wire logic [1:0] cm_level,
    // register port
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // converter outputs
    output logic signed [6:0] dac_level_left,
    output logic signed [6:0] dac_level_right,
    output logic [1:0] bias_current,
    output logic [1:0] cm_select,
    // status and power
    output logic volume_done,
    output logic dac_powered_down,
    output logic [1:0] chan_analog_on,
    output logic deemph_on,
    output logic effects_on
);

    localparam int MOD_HZ = MOD_RATE_MULT * REFERENCE_SAMPLE_RATE_HZ;
    localparam int DLY_DEPTH = GROUP_DELAY - 1;

    if (REFERENCE_SAMPLE_RATE_HZ < REFERENCE_SAMPLE_RATE_MIN_HZ || REFERENCE_SAMPLE_RATE_HZ > REFERENCE_SAMPLE_RATE_MAX_HZ) begin : g_bad_rate
        $error("reference sample rate out of range");
    end
    if (MOD_HZ >= CLK_HZ) begin : g_bad_clk
        $error("master clock too slow for modulator rate");
    end

    // gain for a code: mantissa per 0.5 dB, halving every 12 steps
    localparam logic [16:0] GAIN_MANT [12] = '{17'h08000, 17'h078D7, 17'h0721D, 17'h06BB3,
        17'h065AD, 17'h05FFD, 17'h05A9E, 17'h0558C, 17'h050C3, 17'h04C3F, 17'h047FB, 17'h043F4};
    function automatic logic [16:0] gain_lin(input logic [7:0] code);
        logic [3:0] oct;
        logic [3:0] idx;
        oct = 4'(code[6:0] / STEPS_PER_6DB);
        idx = 4'(code[6:0] % STEPS_PER_6DB);
        if (code[7]) begin
            gain_lin = 17'h00000;
        end else begin
            gain_lin = GAIN_MANT[idx] >> oct;
        end
    endfunction : gain_lin

    // target code from volume and mute
    function automatic logic [7:0] vol_target(input logic [6:0] code, input logic mute);
        vol_target = mute ? VOL_MUTE : {1'b0, code}; // [R20]
    endfunction : vol_target

    ////////////////////////////////////////////////////////////////////////////
    // modulator rate: fractional divider of the master clock

    logic [31:0] nco_q;
    logic mod_tick_q, step_en;
    logic [2:0] div_cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nco_q <= 32'h00000000;
            mod_tick_q <= 1'b0;
        end else if (nco_q + 32'(MOD_HZ) >= 32'(CLK_HZ)) begin
            nco_q <= nco_q + 32'(MOD_HZ) - 32'(CLK_HZ); // [R5]
            mod_tick_q <= 1'b1;
        end else begin
            nco_q <= nco_q + 32'(MOD_HZ);
            mod_tick_q <= 1'b0;
        end
    end

    // interpolation steps once every divider ticks: 128 steps per sample
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_q <= 3'h0;
        end else if (mod_tick_q) begin
            if (div_cnt_q + 3'h1 >= codec_rate_divider) begin
                div_cnt_q <= 3'h0;
            end else begin
                div_cnt_q <= div_cnt_q + 3'h1;
            end
        end
    end

    assign step_en = mod_tick_q && (div_cnt_q + 3'h1 >= codec_rate_divider); // [R1]

    ////////////////////////////////////////////////////////////////////////////
    // power and filter-change sequencer

    seq_state_t state_q;
    logic force_mute, all_muted, all_done, fx_change;
    logic [7:0] tgt [2];
    logic [7:0] applied [2];
    logic [1:0] ch_mute;
    logic [6:0] ch_vol [2];

    assign force_mute = (state_q != S_RUN);
    assign fx_change = (deemph_en != deemph_on) || (effects_en != effects_on);
    assign ch_mute = {mute_right, mute_left};
    assign ch_vol[0] = master_vol_sel ? master_vol : vol_left; // [R7]
    assign ch_vol[1] = master_vol_sel ? master_vol : vol_right; // [R7]
    assign all_muted = (applied[0] == VOL_MUTE) && (applied[1] == VOL_MUTE);
    assign all_done = (applied[0] == tgt[0]) && (applied[1] == tgt[1]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_OFF;
        end else begin
            unique case (state_q)
                S_OFF: begin
                    if (dac_power_en) begin
                        state_q <= S_RUN; // [R15]
                    end
                end
                S_RUN: begin
                    if (!dac_power_en) begin
                        state_q <= S_PWR_MUTE; // [R16]
                    end else if (fx_change) begin
                        state_q <= S_FX_MUTE; // [R14]
                    end
                end
                S_FX_MUTE: begin
                    if (all_muted) begin
                        state_q <= S_RUN; // [R14]
                    end
                end
                S_PWR_MUTE: begin
                    if (dac_power_en) begin
                        state_q <= S_RUN;
                    end else if (all_muted) begin
                        state_q <= S_OFF; // [R16]
                    end
                end
                default: state_q <= S_OFF;
            endcase
        end
    end

    // filtering switches only while both channels sit at mute
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deemph_on <= 1'b0;
            effects_on <= 1'b0;
        end else if (state_q == S_FX_MUTE && all_muted) begin
            deemph_on <= deemph_en; // [R14]
            effects_on <= effects_en; // [R14]
        end
    end

    // status and analog power
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            volume_done <= 1'b0;
            dac_powered_down <= 1'b1;
            chan_analog_on <= 2'b00;
        end else begin
            volume_done <= all_done; // [R10] [R21]
            dac_powered_down <= (state_q == S_OFF) && all_muted; // [R13] [R12]
            chan_analog_on <= (state_q == S_OFF) ? 2'b00 : chan_power_en; // [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port and analog settings

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_current <= BIAS_RESET; // [R17]
        end else if (reg_wr && reg_addr == REG_BIAS_ADDR) begin
            bias_current <= reg_wdata[BIAS_LSB +: 2]; // [R17]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            cm_select <= 2'h0;
        end else begin
            reg_rdata <= (reg_addr == REG_BIAS_ADDR) ? {bias_current, 6'h00} : 8'h00;
            cm_select <= cm_level; // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel volume, interpolation, modulator and reconstruction

    logic ramp_phase_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramp_phase_q <= 1'b0;
        end else if (sample_valid) begin
            ramp_phase_q <= ~ramp_phase_q; // [R9]
        end
    end

    logic signed [6:0] fir_out [2];

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [7:0] applied_q;
        logic signed [15:0] scaled_q;
        logic signed [15:0] dly_q [DLY_DEPTH];
        logic signed [15:0] end_q, x_in;
        logic signed [16:0] diff_q;
        logic signed [23:0] acc_q;
        logic [7:0] steps_q;
        logic signed [MOD_W-1:0] e1_q, e2_q, e3_q;
        logic signed [MOD_W-1:0] v, vq;
        logic signed [3:0] y;
        logic signed [3:0] taps_q [FIR_TAPS];
        logic signed [6:0] fir_sum;
        logic signed [32:0] prod;

        assign tgt[c] = force_mute ? VOL_MUTE : vol_target(ch_vol[c], ch_mute[c]);
        assign applied[c] = applied_q;
        assign x_in = (c == 0) ? sample_left : sample_right;

        // soft stepping of the applied gain
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                applied_q <= VOL_MUTE; // [R15]
            end else if (sample_valid) begin
                if (ramp_off) begin
                    applied_q <= tgt[c]; // [R11] [R21]
                end else if (ramp_slow && !ramp_phase_q) begin
                    applied_q <= applied_q; // [R9]
                end else if (applied_q < tgt[c]) begin
                    applied_q <= applied_q + 8'h01; // [R8]
                end else if (applied_q > tgt[c]) begin
                    applied_q <= applied_q - 8'h01; // [R8]
                end
            end
        end

        assign prod = x_in * $signed(gain_lin(applied_q)); // [R6] [R20]

        // gain applied, then delay line to reach the group delay
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                scaled_q <= 16'sh0000;
                for (int i = 0; i < DLY_DEPTH; i++) begin
                    dly_q[i] <= 16'sh0000;
                end
            end else if (sample_valid) begin
                scaled_q <= prod[GAIN_FRAC +: 16]; // [R6]
                dly_q[0] <= scaled_q;
                for (int i = 1; i < DLY_DEPTH; i++) begin
                    dly_q[i] <= dly_q[i-1]; // [R1]
                end
            end
        end

        // linear interpolation: symmetric kernel, one more sample of delay
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                end_q <= 16'sh0000;
                diff_q <= 17'sh00000;
                acc_q <= 24'sh000000;
                steps_q <= INTERP_STEPS;
            end else if (sample_valid) begin
                end_q <= dly_q[DLY_DEPTH-1];
                diff_q <= 17'(dly_q[DLY_DEPTH-1]) - 17'(end_q); // [R1] [R2]
                acc_q <= 24'(end_q) <<< INTERP_SHIFT;
                steps_q <= 8'h00;
            end else if (step_en && steps_q != INTERP_STEPS) begin
                acc_q <= acc_q + 24'(diff_q); // [R1]
                steps_q <= steps_q + 8'h01;
            end
        end

        // third-order error-feedback noise shaping, 4-bit quantiser
        always_comb begin
            v = MOD_W'($signed(acc_q[INTERP_SHIFT +: 16]) + 3 * e1_q - 3 * e2_q + e3_q); // [R4]
            if ((v >>> QUANT_SHIFT) > MOD_W'(QUANT_MAX)) begin
                y = QUANT_MAX;
            end else if ((v >>> QUANT_SHIFT) < MOD_W'(QUANT_MIN)) begin
                y = QUANT_MIN;
            end else begin
                y = 4'(v >>> QUANT_SHIFT);
            end
            vq = MOD_W'(y) <<< QUANT_SHIFT;
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                e1_q <= '0;
                e2_q <= '0;
                e3_q <= '0;
            end else if (mod_tick_q) begin
                e1_q <= v - vq; // [R4]
                e2_q <= e1_q;
                e3_q <= e2_q;
            end
        end

        // six-tap reconstruction sum at the modulator rate
        always_comb begin
            fir_sum = 7'(y);
            for (int i = 0; i < FIR_TAPS - 1; i++) begin
                fir_sum = fir_sum + 7'(taps_q[i]); // [R5]
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                for (int i = 0; i < FIR_TAPS; i++) begin
                    taps_q[i] <= 4'sh0;
                end
            end else if (mod_tick_q) begin
                taps_q[0] <= y;
                for (int i = 1; i < FIR_TAPS; i++) begin
                    taps_q[i] <= taps_q[i-1]; // [R5]
                end
            end
        end

        assign fir_out[c] = fir_sum;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_level_left <= 7'sh00;
            dac_level_right <= 7'sh00;
        end else if (mod_tick_q) begin
            dac_level_left <= fir_out[0]; // [R5]
            dac_level_right <= fir_out[1]; // [R5]
        end
    end

endmodule : dac_playback_volume_path

// File: rtl/dac_playback_pkg.sv
package dac_playback_pkg;

    // master clock
    localparam int CLK_HZ = 50_000_000;

    // reference sample rate limits with the pll in use
    localparam int REFERENCE_SAMPLE_RATE_DEFAULT_HZ = 48_000;
    localparam int REFERENCE_SAMPLE_RATE_MIN_HZ = 39_000;
    localparam int REFERENCE_SAMPLE_RATE_MAX_HZ = 53_000;

    // modulator and reconstruction rate as a multiple of the reference rate
    localparam int MOD_RATE_MULT = 128;
    localparam int INTERP_SHIFT = 7;
    localparam logic [7:0] INTERP_STEPS = 8'h80;

    // interpolation group delay in input sample periods
    localparam int GROUP_DELAY = 21;

    // register map, page 0
    localparam logic [6:0] REG_BIAS_ADDR = 7'h6D;
    localparam int BIAS_LSB = 6;
    localparam logic [1:0] BIAS_RESET = 2'h0;

    // volume codes: 0.5 dB attenuation steps, code 0x80 is mute
    localparam logic [7:0] VOL_MUTE = 8'h80;
    localparam int STEPS_PER_6DB = 12;
    localparam int GAIN_FRAC = 15;

    // delta-sigma quantiser
    localparam int MOD_W = 20;
    localparam int QUANT_SHIFT = 12;
    localparam logic signed [3:0] QUANT_MAX = 4'sh7;
    localparam logic signed [3:0] QUANT_MIN = -4'sh8;
    localparam int FIR_TAPS = 6;

    typedef enum logic [3:0] {
        S_OFF      = 4'b0001,
        S_RUN      = 4'b0010,
        S_FX_MUTE  = 4'b0100,
        S_PWR_MUTE = 4'b1000
    } seq_state_t;

endpackage : dac_playback_pkg

// File: bench/dac_playback_asserts.sv
`timescale 1ns/100ps
module dac_playback_asserts
    import dac_playback_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] bias_current,
    // settings and status
    input wire logic [1:0] cm_level,
    input wire logic [1:0] cm_select,
    input wire logic dac_power_en,
    input wire logic dac_powered_down,
    input wire logic [1:0] chan_analog_on,
    input wire logic volume_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_bias_write;
        reg_wr && reg_addr == REG_BIAS_ADDR |=> bias_current == $past(reg_wdata[7:6]);
    endproperty
    a_bias_write: assert property (p_bias_write)
        else $error("bias field not taken from write");

    property p_bias_hold;
        !(reg_wr && reg_addr == REG_BIAS_ADDR) |=> $stable(bias_current);
    endproperty
    a_bias_hold: assert property (p_bias_hold)
        else $error("bias field changed without write");

    property p_rdata_map;
        reg_addr == REG_BIAS_ADDR |=> reg_rdata == {$past(bias_current), 6'h00};
    endproperty
    a_rdata_map: assert property (p_rdata_map)
        else $error("bias register read back wrong");

    property p_rdata_unmapped;
        reg_addr != REG_BIAS_ADDR |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_unmapped: assert property (p_rdata_unmapped)
        else $error("unmapped address reads nonzero");

    property p_cm_follow;
        1'b1 |=> cm_select == $past(cm_level);
    endproperty
    a_cm_follow: assert property (p_cm_follow)
        else $error("common-mode select not applied");

    property p_chan_off;
        dac_powered_down |-> chan_analog_on == 2'h0;
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("channel analog on while powered down");

    property p_power_up;
        $rose(dac_power_en) |-> ##[1:3] !dac_powered_down;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up not started");

    property p_pd_after_ramp;
        $rose(dac_powered_down) |-> volume_done;
    endproperty
    a_pd_after_ramp: assert property (p_pd_after_ramp)
        else $error("powered-down flag before ramp done");
endmodule : dac_playback_asserts

bind dac_playback_volume_path dac_playback_asserts dac_playback_asserts_i (
    .clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .bias_current,
    .cm_level, .cm_select, .dac_power_en, .dac_powered_down, .chan_analog_on,
    .volume_done
);

// File: bench/host_stream.sv
`timescale 1ns/100ps
module host_stream #(
    parameter int PERIOD = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample stream
    output logic sample_valid,
    output logic signed [15:0] sample_left,
    output logic signed [15:0] sample_right
);
    int cnt;
    logic signed [15:0] acc;

    initial begin
        cnt = 0;
        acc = 16'sh0100;
        sample_valid = 1'b0;
        sample_left = 16'sh0000;
        sample_right = 16'sh0000;
    end

    // one strobe per sample period, data garbled between strobes
    always @(negedge clk) begin
        if (!rst_n) begin
            cnt <= 0;
            sample_valid <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sample_valid <= (cnt == 0);
            sample_left <= (cnt == 0) ? acc : ~acc;
            sample_right <= (cnt == 0) ? -acc : acc;
            if (cnt == 0) begin
                acc <= acc + 16'sh0111;
            end
        end
    end
endmodule : host_stream

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench
    import dac_playback_pkg::*;
;
    logic clk, rst_n, sample_valid, reg_wr;
    logic signed [15:0] sample_left, sample_right;
    logic [2:0] codec_rate_divider;
    logic dac_power_en, mute_left, mute_right, master_vol_sel, ramp_slow, ramp_off;
    logic deemph_en, effects_en, volume_done, dac_powered_down, deemph_on, effects_on;
    logic [1:0] chan_power_en, cm_level, bias_current, cm_select, chan_analog_on;
    logic [6:0] vol_left, vol_right, master_vol, reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic signed [6:0] dac_level_left, dac_level_right;
    int fails, samples_checked, n;
    logic [1:0] level_seen = 2'b00;

    // converter outputs must move while audio plays
    always @(posedge clk) begin
        if (dac_level_left != 7'sh00) level_seen[0] <= 1'b1;
        if (dac_level_right != 7'sh00) level_seen[1] <= 1'b1;
    end
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [1:0] cm;
        logic [1:0] bias;
        logic [7:0] rdata;
    } row_t;
    row_t rows [5] = '{'{7'h6D, 8'hC0, 2'h0, 2'h3, 8'hC0}, '{7'h6D, 8'h7F, 2'h1, 2'h1, 8'h40},
        '{7'h10, 8'hFF, 2'h2, 2'h1, 8'h00}, '{7'h6D, 8'h80, 2'h3, 2'h2, 8'h80},
        '{7'h6D, 8'h3F, 2'h0, 2'h0, 8'h00}};

    dac_playback_volume_path dac_playback_volume_path_i (.clk, .rst_n, .sample_valid,
        .sample_left, .sample_right, .codec_rate_divider, .dac_power_en, .chan_power_en,
        .vol_left, .vol_right, .mute_left, .mute_right, .master_vol_sel, .master_vol,
        .ramp_slow, .ramp_off, .deemph_en, .effects_en, .cm_level, .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .dac_level_left, .dac_level_right, .bias_current, .cm_select,
        .volume_done, .dac_powered_down, .chan_analog_on, .deemph_on, .effects_on);
    host_stream host_stream_i (.clk, .rst_n, .sample_valid, .sample_left, .sample_right);

    // master clock never stops, also across power-down
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic check_count(input string name, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_count

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // align to just after a sample strobe
    task automatic sync();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (sample_valid !== 1'b1 && k < 20);
        if (k >= 20) begin
            check8("sample_strobe", 8'h01, 8'h00);
            stop_test();
        end
        @(negedge clk);
    endtask : sync

    // samples seen until a flag reads high
    task automatic count_to(input int which, output int cnt);
        logic f;
        int k;
        cnt = 0;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk);
            #1;
            if (sample_valid === 1'b1) cnt++;
            f = which == 0 ? volume_done : which == 1 ? deemph_on :
                which == 2 ? effects_on : dac_powered_down;
            if (k > 2 && f === 1'b1) break;
        end
        if (k >= 3000) begin
            check_count("flag_wait", which, -1);
            stop_test();
        end
        @(negedge clk);
    endtask : count_to

    ////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        samples_checked = 0;
        {rst_n, reg_wr, dac_power_en, mute_left, mute_right, master_vol_sel} = 6'h00;
        {ramp_slow, ramp_off, deemph_en, effects_en} = 4'h0;
        {reg_addr, reg_wdata, vol_left, vol_right, master_vol} = 36'h0;
        codec_rate_divider = 3'h1;
        chan_power_en = 2'h1;
        cm_level = 2'h2;
        repeat (12) @(negedge clk);
        check8("bias_reset", 8'h00, {6'h00, bias_current});
        check8("pd_reset", 8'h01, {7'h00, dac_powered_down});
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            reg_wr = 1'b1;
            reg_addr = rows[i].addr;
            reg_wdata = rows[i].wdata;
            cm_level = rows[i].cm;
            @(negedge clk);
            reg_wr = 1'b0;
            repeat (2) @(negedge clk);
            check8("bias_current", {6'h00, rows[i].bias}, {6'h00, bias_current});
            check8("reg_rdata", rows[i].rdata, reg_rdata);
            check8("cm_select", {6'h00, rows[i].cm}, {6'h00, cm_select});
        end
        sync();
        dac_power_en = 1'b1;
        count_to(0, n);
        check_count("power_up_steps", 128, n);
        check8("chan_on_left", 8'h01, {6'h00, chan_analog_on});
        chan_power_en = 2'h2;
        repeat (2) @(negedge clk);
        check8("chan_on_right", 8'h02, {6'h00, chan_analog_on});
        sync();
        master_vol = 7'h14;
        master_vol_sel = 1'b1;
        count_to(0, n);
        check_count("master_steps", 20, n);
        sync();
        ramp_slow = 1'b1;
        master_vol = 7'h0A;
        count_to(0, n);
        check_count("slow_pairs", 10, (n + 1) / 2);
        sync();
        ramp_slow = 1'b0;
        vol_left = 7'h02;
        vol_right = 7'h02;
        master_vol_sel = 1'b0;
        count_to(0, n);
        check_count("deselect_steps", 8, n);
        for (int f = 1; f < 3; f++) begin
            sync();
            deemph_en = deemph_en | (f == 1);
            effects_en = effects_en | (f == 2);
            count_to(f, n);
            check_count("mute_before_filter", 126, n);
            count_to(0, n);
            check_count("unmute_after_filter", 126, n);
        end
        sync();
        mute_left = 1'b1;
        count_to(0, n);
        check_count("left_mute_steps", 126, n);
        sync();
        dac_power_en = 1'b0;
        count_to(3, n);
        check_count("power_down_steps", 126, n);
        check8("chan_off", 8'h00, {6'h00, chan_analog_on});
        ramp_off = 1'b1;
        sync();
        dac_power_en = 1'b1;
        count_to(0, n);
        check_count("ramp_off_power_up", 1, n);
        sync();
        mute_left = 1'b0;
        count_to(0, n);
        check_count("ramp_off_unmute", 1, n);
        check8("level_activity", 8'h03, {6'h00, level_seen});
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check8("pd_in_reset", 8'h01, {7'h00, dac_powered_down});
        check8("done_in_reset", 8'h00, {7'h00, volume_done});
        check8("filters_in_reset", 8'h00, {6'h00, deemph_on, effects_on});
        check8("chan_in_reset", 8'h00, {6'h00, chan_analog_on});
        check8("level_in_reset", 8'h00, {1'b0, dac_level_left | dac_level_right});
        rst_n = 1'b1;
        @(negedge clk);
        check8("done_after_reset", 8'h01, {7'h00, volume_done});
        check8("pd_after_reset", 8'h01, {7'h00, dac_powered_down});
        stop_test();
    end
endmodule : testbench
